// ---- pkg/asisel_pkg.sv ----
/*
  asisel_pkg: constants shared by the space-identifier selector and the
  reorder hazard window: register offsets, field positions, reset values,
  identifier codes and widths.
  Assumes a 32-bit APB bus with byte addresses and a 40 MHz system clock.
*/
package asisel_pkg;

  // ----------------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_TRAP_LVL = 12'h004;
  localparam logic [11:0] OFS_ASI_REG  = 12'h008;
  localparam logic [11:0] OFS_PRI_CTX  = 12'h00C;
  localparam logic [11:0] OFS_SEC_CTX  = 12'h010;
  localparam logic [11:0] OFS_STATUS   = 12'h014;
  localparam logic [11:0] OFS_WINDOW   = 12'h018;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_PRIV_BIT   = 0;
  localparam int CTRL_CLE_BIT    = 1;
  localparam int CTRL_RENAME_BIT = 2;
  localparam logic [2:0]  CTRL_RST     = 3'h1;
  localparam logic [2:0]  TRAP_LVL_RST = 3'h0;
  localparam logic [7:0]  ASI_REG_RST  = 8'h00;
  localparam int CTX_W = 13;
  localparam logic [12:0] CTX_RST      = 13'h0000;

  // ----------------------------------------------------------------------
  // space identifier codes and limits
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRIMARY_SPACE_CODE    = 8'h80;
  localparam logic [7:0] PRIMARY_SPACE_LE_CODE = 8'h88;
  localparam logic [7:0] SECONDARY_SPACE_CODE  = 8'h81;
  localparam logic [7:0] SECONDARY_SPACE_LE_CODE = 8'h89;
  localparam logic [7:0] NUCLEUS_SPACE_CODE    = 8'h04;
  localparam logic [7:0] NUCLEUS_SPACE_LE_CODE = 8'h0C;
  localparam logic [7:0] PRIV_ONLY_LIMIT       = 8'h30;
  localparam logic [2:0] MAX_PRIVILEGED_TRAP_LEVEL = 3'h2;

  // ----------------------------------------------------------------------
  // access kinds and window size
  // ----------------------------------------------------------------------
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_LOAD  = 2'h1;
  localparam logic [1:0] KIND_STORE = 2'h2;
  localparam int WIN_DEPTH = 4;
  localparam int WIN_AW    = 2;
  localparam int REG_AW    = 5;

  // access path states
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b01,
    ACC_SEND = 2'b10
  } asisel_acc_st_t;

endpackage

// ---- core/asisel_top.sv ----
/*
  asisel_top: picks the space identifier for each memory access, checks it
  against privilege, tags it with a context and hands it to the memory
  management unit; also holds a small reorder window that dispatches
  instructions only when register and memory data-flow hazards are clear.
  Assumes an APB master, an MMU that accepts with valid/ready, and an
  execute stage that reports each dispatched tag when it is performed.
*/
// Functional notes
// - every access carries an 8-bit space code plus a 64-bit offset.
// - unprivileged use of codes with top bit clear raises privilege trap.
// - privileged use of codes 30 to 7F still raises privilege trap.
// - codes 80 to FF are accepted in either privilege mode.
// - codes 00 to 2F are legal only while privileged.
// - at trap level zero implicit accesses use primary, data little if cle.
// - at nonzero trap level implicit fetches use the nucleus code.
// - at nonzero trap level data uses nucleus, little variant if cle.
// - fetch code depends only on trap level, never privilege or cle.
// - alternate code from instruction field, or register in imm form.
// - primary, secondary and nucleus are distinct contexts.
// - each address is qualified by primary, secondary or zero context id.
// - instructions enter the window strictly in program order.
// - reordering never changes results versus in-order execution.
// - reads and writes wait for older writers of the same register.
// - register writers wait for older readers of that register.
// - optional renaming lifts the write-after hazards on registers.
// - loads and stores wait for older stores to the same location.
// - stores wait for older loads from the same location.
module asisel_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // access request from the pipeline
  input  wire logic        acc_valid,
  output logic             acc_ready,
  input  wire logic [1:0]  acc_kind,
  input  wire logic        acc_alt,
  input  wire logic        acc_imm_form,
  input  wire logic [7:0]  acc_insn_asi,
  input  wire logic [63:0] acc_addr,
  // privilege trap report
  output logic             priv_trap,
  output logic [7:0]       priv_trap_asi,
  // towards the memory management unit
  output logic             mmu_valid,
  input  wire logic        mmu_ready,
  output logic [7:0]       mmu_asi,
  output logic [63:0]      mmu_addr,
  output logic [12:0]      mmu_context,
  output logic [1:0]       mmu_kind,
  // instruction issue into the window
  input  wire logic        iss_valid,
  output logic             iss_ready,
  input  wire logic        iss_dst_en,
  input  wire logic [4:0]  iss_dst,
  input  wire logic        iss_src_en,
  input  wire logic [4:0]  iss_src,
  input  wire logic        iss_load,
  input  wire logic        iss_store,
  input  wire logic [63:0] iss_maddr,
  // dispatch and completion
  output logic             ex_valid,
  output logic [1:0]       ex_tag,
  input  wire logic        ex_done,
  input  wire logic [1:0]  ex_done_tag
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // privilege check of a space code
  function automatic logic asi_allowed(input logic priv, input logic [7:0] a);
    if (a[7])
      return 1'b1;
    else if (!priv)
      return 1'b0;
    else
      return (a < asisel_pkg::PRIV_ONLY_LIMIT);
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // apb register file
  // ----------------------------------------------------------------------
  logic [2:0]  ctrl_reg;
  logic [2:0]  trap_lvl_reg;
  logic [7:0]  asi_reg;
  logic [12:0] pri_ctx_reg;
  logic [12:0] sec_ctx_reg;
  logic [15:0] viol_cnt_reg;
  logic [7:0]  last_bad_reg;
  logic [31:0] prdata_reg;
  logic        unmapped_reg;

  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pwrite;
  wire hit_ctrl  = (paddr == asisel_pkg::OFS_CTRL);
  wire hit_tl    = (paddr == asisel_pkg::OFS_TRAP_LVL);
  wire hit_asi   = (paddr == asisel_pkg::OFS_ASI_REG);
  wire hit_pri   = (paddr == asisel_pkg::OFS_PRI_CTX);
  wire hit_sec   = (paddr == asisel_pkg::OFS_SEC_CTX);
  wire hit_stat  = (paddr == asisel_pkg::OFS_STATUS);
  wire hit_win   = (paddr == asisel_pkg::OFS_WINDOW);
  wire hit_any   = hit_ctrl | hit_tl | hit_asi | hit_pri | hit_sec |
                   hit_stat | hit_win;
  wire [31:0] wm_ctrl = merge({29'h0, ctrl_reg}, pwdata, pstrb);
  wire [31:0] wm_tl   = merge({29'h0, trap_lvl_reg}, pwdata, pstrb);
  wire [31:0] wm_asi  = merge({24'h0, asi_reg}, pwdata, pstrb);
  wire [31:0] wm_pri  = merge({19'h0, pri_ctx_reg}, pwdata, pstrb);
  wire [31:0] wm_sec  = merge({19'h0, sec_ctx_reg}, pwdata, pstrb);

  wire        priv_bit   = ctrl_reg[asisel_pkg::CTRL_PRIV_BIT];
  wire        cle_bit    = ctrl_reg[asisel_pkg::CTRL_CLE_BIT];
  wire        rename_bit = ctrl_reg[asisel_pkg::CTRL_RENAME_BIT];

  logic [asisel_pkg::WIN_DEPTH-1:0] w_valid;
  logic [asisel_pkg::WIN_DEPTH-1:0] w_done;

  // read mux; status and window occupancy show block state
  wire [31:0] rd_mux =
      hit_ctrl ? {29'h0, ctrl_reg} :
      hit_tl   ? {29'h0, trap_lvl_reg} :
      hit_asi  ? {24'h0, asi_reg} :
      hit_pri  ? {19'h0, pri_ctx_reg} :
      hit_sec  ? {19'h0, sec_ctx_reg} :
      hit_stat ? {8'h00, last_bad_reg, viol_cnt_reg} :
      hit_win  ? {24'h0, w_done, w_valid} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = psel & penable & unmapped_reg;

  // writes land at the access edge; read data is captured at setup
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg     <= asisel_pkg::CTRL_RST;
      trap_lvl_reg <= asisel_pkg::TRAP_LVL_RST;
      asi_reg      <= asisel_pkg::ASI_REG_RST;
      pri_ctx_reg  <= asisel_pkg::CTX_RST;
      sec_ctx_reg  <= asisel_pkg::CTX_RST;
      prdata_reg   <= 32'h0000_0000;
      unmapped_reg <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata_reg   <= pwrite ? 32'h0000_0000 : rd_mux;
        unmapped_reg <= ~hit_any;
      end
      if (apb_wr && hit_ctrl) ctrl_reg     <= wm_ctrl[2:0];
      if (apb_wr && hit_tl)   trap_lvl_reg <= wm_tl[2:0];
      if (apb_wr && hit_asi)  asi_reg      <= wm_asi[7:0];
      if (apb_wr && hit_pri)  pri_ctx_reg  <= wm_pri[12:0];
      if (apb_wr && hit_sec)  sec_ctx_reg  <= wm_sec[12:0];
    end
  end

  // ----------------------------------------------------------------------
  // space code selection and check
  // ----------------------------------------------------------------------
  wire tl_zero  = (trap_lvl_reg == 3'h0);
  wire is_fetch = (acc_kind == asisel_pkg::KIND_FETCH);
  // fetch ignores cle so a little-endian data mode cannot flip code fetch
  wire [7:0] fetch_asi = tl_zero ? asisel_pkg::PRIMARY_SPACE_CODE
                                 : asisel_pkg::NUCLEUS_SPACE_CODE;
  wire [7:0] data_asi  =
      tl_zero ? (cle_bit ? asisel_pkg::PRIMARY_SPACE_LE_CODE
                         : asisel_pkg::PRIMARY_SPACE_CODE)
              : (cle_bit ? asisel_pkg::NUCLEUS_SPACE_LE_CODE
                         : asisel_pkg::NUCLEUS_SPACE_CODE);
  wire [7:0] alt_asi   = acc_imm_form ? asi_reg : acc_insn_asi;
  wire [7:0] sel_asi   = (acc_alt && !is_fetch) ? alt_asi :
                         (is_fetch ? fetch_asi : data_asi);
  wire       sel_ok    = asi_allowed(priv_bit, sel_asi);
  // context per space: nucleus is its own context id zero
  wire is_pri = (sel_asi == asisel_pkg::PRIMARY_SPACE_CODE) |
                (sel_asi == asisel_pkg::PRIMARY_SPACE_LE_CODE);
  wire is_sec = (sel_asi == asisel_pkg::SECONDARY_SPACE_CODE) |
                (sel_asi == asisel_pkg::SECONDARY_SPACE_LE_CODE);
  wire [12:0] sel_ctx = is_pri ? pri_ctx_reg :
                        is_sec ? sec_ctx_reg : asisel_pkg::CTX_RST;

  // ----------------------------------------------------------------------
  // access path towards the mmu
  // ----------------------------------------------------------------------
  asisel_pkg::asisel_acc_st_t acc_st_reg;
  asisel_pkg::asisel_acc_st_t acc_st_next;
  logic [7:0]  mmu_asi_reg;
  logic [63:0] mmu_addr_reg;
  logic [12:0] mmu_ctx_reg;
  logic [1:0]  mmu_kind_reg;
  logic        trap_reg;
  logic [7:0]  trap_asi_reg;

  assign acc_ready   = (acc_st_reg == asisel_pkg::ACC_IDLE);
  assign mmu_valid   = (acc_st_reg == asisel_pkg::ACC_SEND);
  assign mmu_asi     = mmu_asi_reg;
  assign mmu_addr    = mmu_addr_reg;
  assign mmu_context = mmu_ctx_reg;
  assign mmu_kind    = mmu_kind_reg;
  assign priv_trap   = trap_reg;
  assign priv_trap_asi = trap_asi_reg;

  wire acc_take = acc_valid & acc_ready;

  // next state: a rejected request never enters the send state
  always_comb begin
    acc_st_next = acc_st_reg;
    case (acc_st_reg)
      asisel_pkg::ACC_IDLE:
        if (acc_take && sel_ok) acc_st_next = asisel_pkg::ACC_SEND;
      asisel_pkg::ACC_SEND:
        if (mmu_ready) acc_st_next = asisel_pkg::ACC_IDLE;
      default:
        acc_st_next = asisel_pkg::ACC_IDLE;
    endcase
  end

  // request capture, trap pulse and violation statistics
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_st_reg   <= asisel_pkg::ACC_IDLE;
      mmu_asi_reg  <= 8'h00;
      mmu_addr_reg <= 64'h0;
      mmu_ctx_reg  <= 13'h0000;
      mmu_kind_reg <= 2'h0;
      trap_reg     <= 1'b0;
      trap_asi_reg <= 8'h00;
      viol_cnt_reg <= 16'h0000;
      last_bad_reg <= 8'h00;
    end else begin
      acc_st_reg <= acc_st_next;
      trap_reg   <= acc_take & ~sel_ok;
      if (acc_take && sel_ok) begin
        mmu_asi_reg  <= sel_asi;
        mmu_addr_reg <= acc_addr;
        mmu_ctx_reg  <= sel_ctx;
        mmu_kind_reg <= acc_kind;
      end
      if (acc_take && !sel_ok) begin
        trap_asi_reg <= sel_asi;
        last_bad_reg <= sel_asi;
        viol_cnt_reg <= viol_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // hazard window: in-order entry and retire, out-of-order dispatch
  // ----------------------------------------------------------------------
  logic [asisel_pkg::WIN_DEPTH-1:0] w_disp;
  logic        w_den  [asisel_pkg::WIN_DEPTH];
  logic [4:0]  w_dst  [asisel_pkg::WIN_DEPTH];
  logic        w_sen  [asisel_pkg::WIN_DEPTH];
  logic [4:0]  w_src  [asisel_pkg::WIN_DEPTH];
  logic        w_ld   [asisel_pkg::WIN_DEPTH];
  logic        w_st   [asisel_pkg::WIN_DEPTH];
  logic [60:0] w_loc  [asisel_pkg::WIN_DEPTH];
  logic [1:0]  head_reg;
  logic [1:0]  tail_reg;
  logic [2:0]  count_reg;
  logic [asisel_pkg::WIN_DEPTH-1:0] ready_mask;
  logic        pick_ok;
  logic [1:0]  pick_idx;

  // hazard between a younger entry y and an older unperformed entry o;
  // the location is the doubleword, the unit of ordering for memory
  function automatic logic hazard(input int y, input int o, input logic rn);
    logic h;
    h = 1'b0;
    if (w_den[o] && w_sen[y] && w_dst[o] == w_src[y]) h = 1'b1;
    if (!rn && w_den[o] && w_den[y] && w_dst[o] == w_dst[y]) h = 1'b1;
    if (!rn && w_sen[o] && w_den[y] && w_src[o] == w_dst[y]) h = 1'b1;
    if (w_loc[o] == w_loc[y]) begin
      if (w_st[o] && (w_ld[y] || w_st[y])) h = 1'b1;
      if (w_ld[o] && w_st[y]) h = 1'b1;
    end
    return h;
  endfunction

  // ready entries and oldest-first pick
  always_comb begin
    logic [1:0] yi;
    logic [1:0] oi;
    ready_mask = '0;
    pick_ok    = 1'b0;
    pick_idx   = 2'h0;
    yi = 2'h0;
    oi = 2'h0;
    for (int a = 0; a < asisel_pkg::WIN_DEPTH; a++) begin
      yi = head_reg + a[1:0];
      ready_mask[yi] = w_valid[yi] & ~w_disp[yi];
      for (int b = 0; b < a; b++) begin
        oi = head_reg + b[1:0];
        if (w_valid[oi] && !w_done[oi] && hazard(yi, oi, rename_bit))
          ready_mask[yi] = 1'b0;
      end
      if (ready_mask[yi] && !pick_ok) begin
        pick_ok  = 1'b1;
        pick_idx = yi;
      end
    end
  end

  assign iss_ready = (count_reg != 3'(asisel_pkg::WIN_DEPTH));
  assign ex_valid  = pick_ok;
  assign ex_tag    = pick_idx;

  wire iss_take = iss_valid & iss_ready;
  wire retire   = w_valid[head_reg] & w_done[head_reg];

  // entries are written at the tail only, so program order is kept
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      w_valid   <= '0;
      w_disp    <= '0;
      w_done    <= '0;
      head_reg  <= 2'h0;
      tail_reg  <= 2'h0;
      count_reg <= 3'h0;
    end else begin
      if (pick_ok) w_disp[pick_idx] <= 1'b1;
      if (ex_done) w_done[ex_done_tag] <= 1'b1;
      if (retire) begin
        w_valid[head_reg] <= 1'b0;
        head_reg <= head_reg + 2'h1;
      end
      if (iss_take) begin
        w_valid[tail_reg] <= 1'b1;
        w_disp[tail_reg]  <= 1'b0;
        w_done[tail_reg]  <= 1'b0;
        tail_reg <= tail_reg + 2'h1;
      end
      count_reg <= count_reg + {2'h0, iss_take} - {2'h0, retire};
    end
  end

  // entry payload, no reset needed since valid gates every use
  always_ff @(posedge clk_sys) begin
    if (iss_take) begin
      w_den[tail_reg] <= iss_dst_en;
      w_dst[tail_reg] <= iss_dst;
      w_sen[tail_reg] <= iss_src_en;
      w_src[tail_reg] <= iss_src;
      w_ld[tail_reg]  <= iss_load;
      w_st[tail_reg]  <= iss_store;
      w_loc[tail_reg] <= iss_maddr[63:3];
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_reject_no_mmu;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_take && !sel_ok) |=> priv_trap && !mmu_valid;
  endproperty
  a_reject_no_mmu: assert property (p_reject_no_mmu)
    else $error("rejected access reached the mmu");

  property p_unpriv_low;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_take && !priv_bit && !sel_asi[7]) |=> priv_trap;
  endproperty
  a_unpriv_low: assert property (p_unpriv_low)
    else $error("unprivileged restricted code not trapped");

  property p_priv_mid;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_take && priv_bit && !sel_asi[7] &&
     sel_asi >= asisel_pkg::PRIV_ONLY_LIMIT) |=> priv_trap;
  endproperty
  a_priv_mid: assert property (p_priv_mid)
    else $error("privileged use of 30 to 7F not trapped");

  property p_high_ok;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_take && sel_asi[7]) |=> mmu_valid && !priv_trap
                                 && mmu_asi == $past(sel_asi);
  endproperty
  a_high_ok: assert property (p_high_ok)
    else $error("nonrestricted code refused");

  property p_fetch_code;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_take && is_fetch && priv_bit) |=>
      mmu_asi == ($past(tl_zero) ? asisel_pkg::PRIMARY_SPACE_CODE
                                 : asisel_pkg::NUCLEUS_SPACE_CODE);
  endproperty
  a_fetch_code: assert property (p_fetch_code)
    else $error("fetch code wrong for trap level");

  property p_data_le;
    @(posedge clk_sys) disable iff (sys_rst)
    (acc_take && !acc_alt && !is_fetch && cle_bit && priv_bit) |=>
      mmu_asi == ($past(tl_zero) ? asisel_pkg::PRIMARY_SPACE_LE_CODE
                                 : asisel_pkg::NUCLEUS_SPACE_LE_CODE);
  endproperty
  a_data_le: assert property (p_data_le)
    else $error("little-endian implicit data code wrong");

  property p_mmu_hold;
    @(posedge clk_sys) disable iff (sys_rst)
    (mmu_valid && !mmu_ready) |=> mmu_valid && $stable(mmu_addr)
                                  && $stable(mmu_asi);
  endproperty
  a_mmu_hold: assert property (p_mmu_hold)
    else $error("mmu request changed before acceptance");

  property p_no_dispatch_conflict;
    @(posedge clk_sys) disable iff (sys_rst)
    // checked against the next older slot directly, not through hazard()
    (ex_valid && ex_tag != head_reg && w_valid[ex_tag - 2'h1] &&
     !w_done[ex_tag - 2'h1] && w_den[ex_tag - 2'h1] && w_sen[ex_tag])
      |-> w_dst[ex_tag - 2'h1] != w_src[ex_tag];
  endproperty
  a_no_dispatch_conflict: assert property (p_no_dispatch_conflict)
    else $error("dispatched entry not ready");

  property p_order_kept;
    @(posedge clk_sys) disable iff (sys_rst)
    iss_take |=> w_valid[$past(tail_reg)] && tail_reg == $past(tail_reg) + 2'h1;
  endproperty
  a_order_kept: assert property (p_order_kept)
    else $error("issue not placed at tail");

endmodule // asisel_top

// ---- verif/asisel_mmu_model.sv ----
/* asisel_mmu_model: stand-in for the memory management unit.
   Assumes a valid/ready handshake on the selector's mmu side. */
module asisel_mmu_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // handshake with the selector
  input  wire logic mmu_valid,
  output logic      mmu_ready = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ready wanders so that both prompt and slow acceptance occur
  always @(posedge clk_sys) begin
    if (sys_rst)
      mmu_ready <= 1'b0;
    else
      mmu_ready <= ($urandom % 3) != 0;
  end
endmodule  // asisel_mmu_model

// ---- verif/asi_select_and_hazard_check_test.sv ----
/* asi_select_and_hazard_check_test: self-checking bench for asisel_top.
   Assumes the package, the design and asisel_mmu_model compile first. */
module asi_select_and_hazard_check_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, acc_ready, priv_trap, mmu_valid, mmu_ready;
  logic        acc_valid = 0, acc_alt = 0, acc_imm_form = 0, e, pv, le;
  logic [1:0]  acc_kind = 0, mmu_kind, ex_tag, ex_done_tag = 0, k, slot;
  logic [7:0]  acc_insn_asi = 0, priv_trap_asi, mmu_asi, ar, c, ex;
  logic [63:0] acc_addr = 0, mmu_addr, iss_maddr = 0;
  logic [12:0] mmu_context, pc, sc, cx;
  logic        iss_valid = 0, iss_ready, iss_dst_en = 0, iss_src_en = 0;
  logic [4:0]  iss_dst = 0, iss_src = 0;
  logic        iss_load = 0, iss_store = 0, ex_valid, ex_done = 0;
  logic        alt, imf, tr;
  logic [2:0]  tl;
  logic [31:0] rv;
  int          errors = 0, n_checks = 0, cyc = 0, nt = 0;
  logic [7:0]  lb = 0;
  logic [1:0]  disp[$];
  logic [7:0]  cl[8] = '{8'h00, 8'h2F, 8'h30, 8'h7F, 8'h80, 8'hFF,
                         8'h81, 8'h89};
  // pair table {dst_en, src_en, load, store, reg}: hazards first
  logic [8:0]  ta[6] = '{9'h103, 9'h085, 9'h020, 9'h040, 9'h101, 9'h085};
  logic [8:0]  tb[6] = '{9'h083, 9'h105, 9'h040, 9'h020, 9'h102, 9'h105};

  asisel_top asisel_top_inst (.clk_sys, .sys_rst, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb(4'hF), .pready, .prdata, .pslverr, .acc_valid,
    .acc_ready, .acc_kind, .acc_alt, .acc_imm_form, .acc_insn_asi,
    .acc_addr, .priv_trap, .priv_trap_asi, .mmu_valid, .mmu_ready,
    .mmu_asi, .mmu_addr, .mmu_context, .mmu_kind, .iss_valid, .iss_ready,
    .iss_dst_en, .iss_dst, .iss_src_en, .iss_src, .iss_load, .iss_store,
    .iss_maddr, .ex_valid, .ex_tag, .ex_done, .ex_done_tag);
  asisel_mmu_model asisel_mmu_model_inst (.clk_sys, .sys_rst, .mmu_valid,
    .mmu_ready);

  always #12.5 clk_sys = ~clk_sys;
  // dispatches seen at each edge, in order
  always @(posedge clk_sys) if (ex_valid === 1'b1) disp.push_back(ex_tag);
  // cut a hang short; the full run needs about two thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      test_done;
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // one access with the expectation held in ex, tr and cx
  task automatic acc;
    @(posedge clk_sys);
    {acc_valid, acc_kind, acc_alt, acc_imm_form} <= {1'b1, k, alt, imf};
    acc_insn_asi <= c;
    acc_addr <= {$urandom, $urandom};
    do @(posedge clk_sys); while (acc_ready !== 1'b1);
    acc_valid <= 1'b0;
    #1;
    chk({priv_trap, mmu_valid}, {tr, !tr});
    if (tr) chk(priv_trap_asi, ex);
    else begin
      chk({mmu_asi, mmu_kind, mmu_context}, {ex, k, cx});
      chk(mmu_addr, acc_addr);
      while (mmu_valid === 1'b1) @(posedge clk_sys);
    end
  endtask
  task automatic iss(input logic [8:0] t, input logic [63:0] ad);
    @(posedge clk_sys);
    {iss_valid, iss_dst_en, iss_dst, iss_src_en, iss_src, iss_load,
     iss_store, iss_maddr} <= {1'b1, t[8], t[4:0], t[7], t[4:0], t[6:5], ad};
    do @(posedge clk_sys); while (iss_ready !== 1'b1);
    iss_valid <= 1'b0;
  endtask
  task automatic done(input logic [1:0] t);
    @(posedge clk_sys);
    {ex_done, ex_done_tag} <= {1'b1, t};
    @(posedge clk_sys);
    ex_done <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32300));
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(0, asisel_pkg::OFS_CTRL, 0);
    chk(r, {29'h0, asisel_pkg::CTRL_RST});
    apb(1, 12'h040, 32'hFFFFFFFF);
    apb(0, 12'h040, 0);
    chk({e, r}, {1'b1, 32'h0});
    for (int i = 0; i < 80; i++) begin
      rv = $urandom;
      {pv, le, tl, ar} = {rv[0], rv[1], rv[4:2] & {3{rv[5]}}, cl[rv[8:6]]};
      c = rv[9] ? cl[rv[12:10]] : rv[20:13];
      {k, alt, imf, pc, sc} = {rv[22:21] % 2'd3, rv[24:23], 26'($urandom)};
      apb(1, asisel_pkg::OFS_CTRL, {30'h0, le, pv});
      apb(1, asisel_pkg::OFS_TRAP_LVL, {29'h0, tl});
      apb(1, asisel_pkg::OFS_ASI_REG, {24'h0, ar});
      apb(1, asisel_pkg::OFS_PRI_CTX, {19'h0, pc});
      apb(1, asisel_pkg::OFS_SEC_CTX, {19'h0, sc});
      apb(0, asisel_pkg::OFS_TRAP_LVL, 0);
      chk(r, {29'h0, tl});
      if (k == asisel_pkg::KIND_FETCH)
        ex = (tl == 0) ? asisel_pkg::PRIMARY_SPACE_CODE
                       : asisel_pkg::NUCLEUS_SPACE_CODE;
      else if (alt)
        ex = imf ? ar : c;
      else if (tl == 0)
        ex = le ? asisel_pkg::PRIMARY_SPACE_LE_CODE
                : asisel_pkg::PRIMARY_SPACE_CODE;
      else
        ex = le ? asisel_pkg::NUCLEUS_SPACE_LE_CODE
                : asisel_pkg::NUCLEUS_SPACE_CODE;
      tr = !ex[7] &&
           (!pv || ex >= asisel_pkg::PRIV_ONLY_LIMIT);
      // model of the violation statistics
      if (tr) begin
        nt++;
        lb = ex;
      end
      cx = 13'h0;
      if (ex inside {asisel_pkg::PRIMARY_SPACE_CODE,
                     asisel_pkg::PRIMARY_SPACE_LE_CODE}) cx = pc;
      if (ex inside {asisel_pkg::SECONDARY_SPACE_CODE,
                     asisel_pkg::SECONDARY_SPACE_LE_CODE}) cx = sc;
      acc;
    end
    apb(0, asisel_pkg::OFS_STATUS, 0);
    chk(r, {8'h00, lb, nt[15:0]});
    // pairs 0..3 must stall the younger entry; 4 and 5 must not
    slot = 0;
    for (int j = 0; j < 6; j++) begin
      if (j == 5) apb(1, asisel_pkg::OFS_CTRL, 32'h5);
      disp.delete();
      iss(ta[j], 64'h100 * j);
      iss(tb[j], 64'h100 * j + 4);
      repeat (4) @(posedge clk_sys);
      chk(disp.size(), (j < 4) ? 1 : 2);
      chk(disp[0], slot);
      done(slot);
      repeat (3) @(posedge clk_sys);
      chk({disp.size(), disp[1]}, {32'd2, slot + 2'd1});
      done(slot + 2'd1);
      slot += 2'd2;
    end
    apb(0, asisel_pkg::OFS_WINDOW, 0);
    chk(r[3:0], 4'h0);
    test_done;
  end
endmodule  // asi_select_and_hazard_check_test
